// file: src/adc_sequence_input_select.sv
`timescale 1ns/100ps
module adc_sequence_input_select
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [DATA_W/8-1:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic seq_trigger,
  input wire logic conv_done,
  output logic conv_start_ff,
  output logic [SEL_W-1:0] ain_sel_ff,
  output logic temp_sensor_sel_ff,
  output logic seq_busy
);
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] aw_addr_ff;
  logic [DATA_W-1:0] w_data_ff;
  logic [DATA_W/8-1:0] w_strb_ff;
  logic wr_go;
  logic wr_sel;
  logic wr_ctl;
  logic wr_seq;
  logic [SEL_W-1:0] field_sel [STEPS];
  logic [DATA_W-1:0] input_sel_word;
  logic [STEPS-1:0] step_end_of_sequence_ff;
  logic [STEPS-1:0] step_temp_sensor_sel_ff;
  logic start_req;
  seq_state_t state_ff;
  seq_state_t nxt_state;
  logic [STEP_W-1:0] step_ff;
  logic [DATA_W-1:0] rd_word;
  logic rd_hit;

  // address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
  assign wr_go = aw_got_ff && w_got_ff && !s_axi_bvalid;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_ff <= 1'b1;
      aw_addr_ff <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_got_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_got_ff <= 1'b0;
      w_data_ff <= '0;
      w_strb_ff <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_ff <= 1'b1;
      w_data_ff <= s_axi_wdata;
      w_strb_ff <= s_axi_wstrb;
    end else if (wr_go) begin
      w_got_ff <= 1'b0;
    end
  end

  // write decode
  assign wr_sel = wr_go && (aw_addr_ff == OFS_INPUT_SEL);
  assign wr_ctl = wr_go && (aw_addr_ff == OFS_STEP_CTL);
  assign wr_seq = wr_go && (aw_addr_ff == OFS_SEQ_CTL);

  // write response; unmapped addresses answer slverr and store nothing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_sel || wr_ctl || wr_seq) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // one select field per step, field k at bits 4k+2:4k
  for (genvar k = 0; k < STEPS; k++) begin : g_field
    step_sel_field #(
      .LSB(k * FIELD_PITCH)
    ) u_field (
      .clk(clk),
      .sys_rst(sys_rst),
      .wr_en(wr_sel),
      .wr_data(w_data_ff),
      .wr_strb(w_strb_ff),
      .sel_ff(field_sel[k])
    );
  end

  // gap bit above each field stays zero on read and has no storage
  always_comb begin
    input_sel_word = '0;
    for (int k = 0; k < STEPS; k++) begin
      input_sel_word[k*FIELD_PITCH +: SEL_W] = field_sel[k];
    end
  end

  // per-step end and temperature flags
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_end_of_sequence_ff <= FLAGS_RESET;
      step_temp_sensor_sel_ff <= FLAGS_RESET;
    end else if (wr_ctl) begin
      if (w_strb_ff[END_LSB/8]) begin
        step_end_of_sequence_ff <= w_data_ff[END_LSB +: STEPS];
      end
      if (w_strb_ff[TS_LSB/8]) begin
        step_temp_sensor_sel_ff <= w_data_ff[TS_LSB +: STEPS];
      end
    end
  end

  // a start while busy is dropped: the running sequence finishes untouched
  assign start_req = (wr_seq && w_strb_ff[START_BIT/8] && w_data_ff[START_BIT]) || seq_trigger;
  assign seq_busy = (state_ff != SEQ_IDLE);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SEQ_IDLE: begin
        if (start_req) begin
          nxt_state = SEQ_LOAD;
        end
      end
      SEQ_LOAD: begin
        nxt_state = SEQ_CONV;
      end
      SEQ_CONV: begin
        if (conv_done) begin
          // later steps are skipped whatever their fields hold
          if (step_end_of_sequence_ff[step_ff] || step_ff == LAST_STEP) begin
            nxt_state = SEQ_IDLE;
          end else begin
            nxt_state = SEQ_LOAD;
          end
        end
      end
      default: begin
        nxt_state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= SEQ_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // step counter restarts at the first step on every new sequence
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      step_ff <= '0;
    end else if (state_ff == SEQ_IDLE) begin
      step_ff <= '0;
    end else if (state_ff == SEQ_CONV && nxt_state == SEQ_LOAD) begin
      step_ff <= step_ff + 3'h1;
    end
  end

  // field sampled only at step start, so a later write waits for the next pass
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ain_sel_ff <= SEL_RESET;
      temp_sensor_sel_ff <= 1'b0;
      conv_start_ff <= 1'b0;
    end else begin
      conv_start_ff <= (state_ff == SEQ_LOAD);
      if (state_ff == SEQ_LOAD) begin
        ain_sel_ff <= field_sel[step_ff];
        temp_sensor_sel_ff <= step_temp_sensor_sel_ff[step_ff];
      end
    end
  end

  // read decode
  always_comb begin
    rd_word = '0;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      OFS_INPUT_SEL: rd_word = input_sel_word;
      OFS_STEP_CTL: begin
        rd_word[END_LSB +: STEPS] = step_end_of_sequence_ff;
        rd_word[TS_LSB +: STEPS] = step_temp_sensor_sel_ff;
      end
      OFS_SEQ_CTL: begin
        rd_word[BUSY_BIT] = seq_busy;
        rd_word[CUR_STEP_LSB +: STEP_W] = step_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : adc_sequence_input_select

// file: src/adc_seq_pkg.sv
package adc_seq_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STEPS = 8;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned STEP_W = 3;
  localparam int unsigned FIELD_PITCH = 4;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_INPUT_SEL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_STEP_CTL = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_SEQ_CTL = 12'h008;
  // step control layout: end flags in byte 0, temperature flags in byte 1
  localparam int unsigned END_LSB = 0;
  localparam int unsigned TS_LSB = 8;
  // sequence control layout
  localparam int unsigned START_BIT = 0;
  localparam int unsigned BUSY_BIT = 0;
  localparam int unsigned CUR_STEP_LSB = 4;
  // reset values and last step index
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [STEPS-1:0] FLAGS_RESET = 8'h00;
  localparam logic [STEP_W-1:0] LAST_STEP = 3'h7;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LOAD = 2'b01,
    SEQ_CONV = 2'b10
  } seq_state_t;
endpackage : adc_seq_pkg

// file: src/step_sel_field.sv
`timescale 1ns/100ps
// one 3-bit input select field of the select register
module step_sel_field
  import adc_seq_pkg::*;
#(
  parameter int unsigned LSB = 0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W/8-1:0] wr_strb,
  output logic [SEL_W-1:0] sel_ff
);
  // a field never straddles a byte, so one strobe governs it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel_ff <= SEL_RESET;
    end else if (wr_en && wr_strb[LSB/8]) begin
      sel_ff <= wr_data[LSB +: SEL_W];
    end
  end
endmodule : step_sel_field

// file: verif/adc_sequence_input_select_monitor.sv
`timescale 1ns/100ps
module adc_sequence_input_select_monitor
  import adc_seq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic seq_trigger,
  input wire logic conv_done,
  input wire logic conv_start_ff,
  input wire logic [SEL_W-1:0] ain_sel_ff,
  input wire logic temp_sensor_sel_ff,
  input wire logic seq_busy
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // a step launch is a single start strobe
  sequence s_launch;
    conv_start_ff ##1 !conv_start_ff;
  endsequence
  AST_TRIG_START: assert property (seq_trigger && !seq_busy |=> seq_busy ##1 s_launch)
    else $error("trigger did not start a step");
  AST_BUSY_LAUNCH: assert property ($rose(seq_busy) |=> s_launch)
    else $error("no step start after busy");
  AST_SEL_HOLD: assert property (!conv_start_ff |-> $stable(ain_sel_ff))
    else $error("input select moved between steps");
  AST_TEMP_HOLD: assert property (!conv_start_ff |-> $stable(temp_sensor_sel_ff))
    else $error("temp select moved between steps");
  AST_NEXT_STEP: assert property (conv_done && seq_busy && !conv_start_ff
    |=> !seq_busy or (seq_busy ##1 s_launch))
    else $error("bad step after conversion done");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule : adc_sequence_input_select_monitor

bind adc_sequence_input_select adc_sequence_input_select_monitor mon (
  .clk(clk),
  .sys_rst(sys_rst),
  .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .seq_trigger(seq_trigger),
  .conv_done(conv_done),
  .conv_start_ff(conv_start_ff),
  .ain_sel_ff(ain_sel_ff),
  .temp_sensor_sel_ff(temp_sensor_sel_ff),
  .seq_busy(seq_busy)
);

// file: verif/adc_sequence_input_select_test.sv
`timescale 1ns/100ps
module adc_sequence_input_select_test;
  import adc_seq_pkg::*;
  localparam logic [31:0] SEL_A = 32'h01234567;
  logic clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, seq_busy, seq_trigger, conv_done, conv_start_ff, temp_sensor_sel_ff;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [SEL_W-1:0] ain_sel_ff;
  int error_cnt = 0;
  int n_tests = 0;

  adc_sequence_input_select uut (.*);

  // free-running 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // a wait that ran out of cycles ends the run
  task automatic tmo(input int i);
    if (i >= 50) begin
      error_cnt++;
      print_verdict();
    end
  endtask : tmo

  // leading edge keeps a stale answer of the last access from ending the wait
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && !s_axi_bvalid; i++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    tmo(i);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask : wr

  // rready rises only after rvalid, so the slave must hold its answer
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 50 && !(s_axi_rvalid && s_axi_rready); i++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      // raised once only, so the release below is its single change at the last edge
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    tmo(i);
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask : rd

  // one conversion step: check the selection, then report the conversion done
  task automatic step(input logic [2:0] es, input logic et);
    int i;
    @(posedge clk);
    for (i = 0; i < 50 && !conv_start_ff; i++) @(posedge clk);
    tmo(i);
    chk("ain_sel", 32'(es), 32'(ain_sel_ff));
    chk("temp_sel", 32'(et), 32'(temp_sensor_sel_ff));
    conv_done <= 1'b1;
    @(posedge clk);
    conv_done <= 1'b0;
  endtask : step

  // after the last step no further start and the sequencer goes idle
  task automatic quiet;
    repeat (4) begin
      @(posedge clk);
      chk("conv_start", 32'h0, 32'(conv_start_ff));
    end
    chk("busy", 32'h0, 32'(seq_busy));
  endtask : quiet

  initial begin
    int k;
    clk = 1'b0;
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {seq_trigger, conv_done} = 2'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_INPUT_SEL, 32'h0, RESP_OKAY);
    wr(OFS_INPUT_SEL, 32'hffffffff, RESP_OKAY);
    rd(OFS_INPUT_SEL, 32'h77777777, RESP_OKAY);
    wr(12'h00c, 32'h00000005, RESP_SLVERR);
    rd(12'h00c, 32'h0, RESP_SLVERR);
    wr(OFS_INPUT_SEL, SEL_A, RESP_OKAY);
    rd(OFS_INPUT_SEL, SEL_A, RESP_OKAY);
    wr(OFS_STEP_CTL, 32'h00000440, RESP_OKAY);
    rd(OFS_STEP_CTL, 32'h00000440, RESP_OKAY);
    seq_trigger <= 1'b1;
    @(posedge clk);
    seq_trigger <= 1'b0;
    for (k = 0; k < 7; k++) step(SEL_A[4*k +: 3], k == 2);
    quiet();
    wr(OFS_STEP_CTL, 32'h00000001, RESP_OKAY);
    wr(OFS_INPUT_SEL, 32'h00000003, RESP_OKAY);
    wr(OFS_SEQ_CTL, 32'h00000001, RESP_OKAY);
    step(3'h3, 1'b0);
    quiet();
    // reset while idle after the second sequence: written fields and flags must come back as zero
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(OFS_INPUT_SEL, 32'h0, RESP_OKAY);
    rd(OFS_STEP_CTL, 32'h0, RESP_OKAY);
    print_verdict();
  end
endmodule : adc_sequence_input_select_test
